// >>> hw/map_pkg.sv
// Constants and types shared by the debug memory access port.
// Operation
// R1: Transfer address is target or base address.
// R2: Address advances only on successful data access.
// R3: Banked and direct accesses never advance address.
// R4: Step mode codes off, single, packed, reserved.
// R5: Unsupported packed code acts and reads as off.
// R6: Single mode adds access size; off keeps address.
// R7: Word-only device always steps by four.
// R8: Sub-word sizes imply packed; word-only excludes it.
// R9: Packed halfword: two transfers, step two each.
// R10: Packed byte: four transfers, step one each.
// R11: Incrementer covers at least low ten bits.
// R12: Width code reports incrementer width and wrap.
// R13: Debugger manages address when width code zero.
// R14: Data accesses stall until downstream access completes.
// R15: Ready accepted while idle, before target accepts.
// R16: Busy while transfer outstanding, ready when done.
// R17: Requests arriving while busy are discarded.
// R18: Debugger may retry until accepted.
// R19: Memory access errors are logged.
// R20: Forward-disable and halt-on-error control bits.
// R21: Halt with logged error blocks further accesses.
// R22: Forwarding enabled returns errors upstream.
// R23: Abort during access logs and returns error.
// R24: Wrap leaves bits above incrementer unchanged.
`default_nettype none
package map_pkg;
   localparam int ADDR_W_DEF = 32;
   localparam int INC_W_MIN = 10;
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_SINGLE = 2'h1;
   localparam logic [1:0] MODE_PACKED = 2'h2;
   localparam logic [2:0] SIZE_BYTE = 3'h0;
   localparam logic [2:0] SIZE_HALF = 3'h1;
   localparam logic [2:0] SIZE_WORD = 3'h2;
   localparam logic [2:0] STEP_BYTE = 3'h1;
   localparam logic [2:0] STEP_HALF = 3'h2;
   localparam logic [2:0] STEP_WORD = 3'h4;
   localparam logic [2:0] BEATS_HALF = 3'h2;
   localparam logic [2:0] BEATS_BYTE = 3'h4;
   localparam int BANK_LSB = 4;
   localparam int DIRECT_LSB = 10;
   typedef enum logic [1:0] {
      REQ_DATA,
      REQ_BANKED,
      REQ_DIRECT
   } req_kind_t;
endpackage : map_pkg
`default_nettype wire

// >>> hw/addr_step_if.sv
// Carrier between the port and its address incrementer.
`default_nettype none
interface addr_step_if #(parameter int ADDR_W = 32);
   logic [ADDR_W-1:0] addr;
   logic [2:0] step;
   logic [ADDR_W-1:0] next;
   modport user (output addr, output step, input next);
   modport stepper (input addr, input step, output next);
endinterface : addr_step_if
`default_nettype wire

// >>> hw/addr_stepper.sv
// Address incrementer that wraps inside its own segment.
`default_nettype none
module addr_stepper
   import map_pkg::*;
#(
   parameter int ADDR_W = 32,
   parameter int INC_W = 10
)
(
   addr_step_if.stepper s
);
   logic [INC_W-1:0] low_sum;

   // Only the low segment counts; the carry out is dropped on purpose.
   assign low_sum = s.addr[INC_W-1:0] + INC_W'(s.step); // R11
   generate
      if (INC_W < ADDR_W)
      begin : g_upper
         assign s.next = {s.addr[ADDR_W-1:INC_W], low_sum}; // R24
      end
      else
      begin : g_full
         assign s.next = low_sum;
      end
   endgenerate
endmodule : addr_stepper
`default_nettype wire

// >>> hw/mem_access_port.sv
// Transfer core of the debug memory access port.
`default_nettype none
module mem_access_port
   import map_pkg::*;
#(
   parameter int ADDR_W = ADDR_W_DEF,
   parameter int INC_W = INC_W_MIN,
   parameter bit SUBWORD_EN = 1'b1
)
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Configuration writes.
   input wire logic tar_wr_i,
   input wire logic [ADDR_W-1:0] tar_wdata_i,
   input wire logic mode_wr_i,
   input wire logic [1:0] mode_wdata_i,
   input wire logic [2:0] access_size_field_i,
   input wire logic error_forward_disable_i,
   input wire logic halt_on_error_i,
   input wire logic err_clear_i,
   // Requests from the debug port.
   input wire logic req_valid_i,
   input wire req_kind_t req_kind_i,
   input wire logic req_write_i,
   input wire logic [7:0] req_index_i,
   input wire logic [31:0] req_wdata_i,
   input wire logic abort_i,
   // Answers to the debug port.
   output logic ready_o,
   output logic resp_valid_o,
   output logic resp_err_o,
   output logic [31:0] resp_rdata_o,
   // Status.
   output logic [ADDR_W-1:0] transfer_address_o,
   output logic [1:0] addr_step_mode_o,
   output logic [3:0] incrementer_width_code_o,
   output logic logged_error_flag_o,
   // Downstream memory bus.
   output logic bus_req_o,
   output logic bus_write_o,
   output logic [ADDR_W-1:0] bus_addr_o,
   output logic [2:0] bus_size_o,
   output logic [31:0] bus_wdata_o,
   input wire logic bus_ack_i,
   input wire logic bus_err_i,
   input wire logic [31:0] bus_rdata_i
);
   // Packed transfers exist exactly when sub-word sizes do.
   localparam bit PACKED_EN = SUBWORD_EN; // R8
   localparam logic [3:0] WIDTH_CODE = (INC_W == INC_W_MIN) ? 4'h1 : 4'(INC_W - 9); // R12

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_XFER,
      ST_RESP
   } state_t;

   state_t state_r;
   logic [ADDR_W-1:0] tar_r;
   logic [1:0] mode_r;
   logic err_r;
   logic [2:0] beats_r;
   logic [2:0] size_r;
   logic data_r;
   logic done_ok;
   logic done_err;
   logic beat_ok;
   logic [31:0] lane_mask;

   addr_step_if #(.ADDR_W(ADDR_W)) stp ();

   addr_stepper #(.ADDR_W(ADDR_W), .INC_W(INC_W)) u_step (
      .s(stp.stepper)
   );

   function automatic logic [2:0] eff_size(input logic [2:0] sz);
      eff_size = (SUBWORD_EN && (sz == SIZE_BYTE || sz == SIZE_HALF)) ? sz : SIZE_WORD;
   endfunction : eff_size

   function automatic logic [2:0] size_step(input logic [2:0] sz);
      case (sz)
         SIZE_BYTE: size_step = STEP_BYTE;
         SIZE_HALF: size_step = STEP_HALF;
         default: size_step = STEP_WORD; // R7
      endcase
   endfunction : size_step

   function automatic logic [31:0] lanes(input logic [2:0] sz, input logic [1:0] lo);
      case (sz)
         SIZE_BYTE: lanes = 32'h0000_00FF << {lo, 3'h0};
         SIZE_HALF: lanes = lo[1] ? 32'hFFFF_0000 : 32'h0000_FFFF;
         default: lanes = 32'hFFFF_FFFF;
      endcase
   endfunction : lanes

   assign stp.addr = tar_r;
   assign stp.step = size_step(size_r);
   assign lane_mask = lanes(size_r, bus_addr_o[1:0]);

   // A beat ends on the bus answer unless an abort has already claimed it.
   assign beat_ok = (state_r == ST_XFER) && bus_ack_i && !bus_err_i && !abort_i;
   assign done_err = (state_r == ST_XFER) && (abort_i || (bus_ack_i && bus_err_i));
   assign done_ok = beat_ok && (beats_r == 3'h1);

   // Step mode register; an unsupported packed code is stored as off.
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         mode_r <= MODE_OFF;
      end
      else if (mode_wr_i)
      begin
         if (mode_wdata_i == MODE_PACKED && !PACKED_EN)
         begin
            mode_r <= MODE_OFF; // R5
         end
         else
         begin
            mode_r <= mode_wdata_i; // R4
         end
      end
   end

   // Transfer address register.
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         tar_r <= '0;
      end
      else if (tar_wr_i && state_r == ST_IDLE)
      begin
         tar_r <= tar_wdata_i;
      end
      else if (beat_ok && data_r)
      begin
         // Packed sub-word steps after every beat; single and packed word only after the last.
         if (mode_r == MODE_PACKED && size_r != SIZE_WORD)
         begin
            tar_r <= stp.next; // R9 R10
         end
         else if ((mode_r == MODE_SINGLE || mode_r == MODE_PACKED) && beats_r == 3'h1)
         begin
            tar_r <= stp.next; // R2 R6
         end
      end
   end

   // Error log; a new error wins over a clear in the same cycle.
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         err_r <= 1'b0;
      end
      else if (done_err)
      begin
         err_r <= 1'b1; // R19 R23
      end
      else if (state_r == ST_IDLE && req_valid_i && err_r && halt_on_error_i)
      begin
         err_r <= 1'b1; // R21
      end
      else if (err_clear_i)
      begin
         err_r <= 1'b0;
      end
   end

   // Sequencer and downstream bus drive.
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_r <= ST_IDLE;
         beats_r <= 3'h0;
         size_r <= SIZE_WORD;
         data_r <= 1'b0;
         bus_req_o <= 1'b0;
         bus_write_o <= 1'b0;
         bus_addr_o <= '0;
         bus_size_o <= SIZE_WORD;
         bus_wdata_o <= 32'h0000_0000;
         resp_valid_o <= 1'b0;
         resp_err_o <= 1'b0;
         resp_rdata_o <= 32'h0000_0000;
      end
      else
      begin
         resp_valid_o <= 1'b0;
         case (state_r)
            ST_IDLE:
            begin
               // Busy requests never reach this branch and so are dropped.
               if (req_valid_i) // R15 R17
               begin
                  data_r <= (req_kind_i == REQ_DATA);
                  resp_rdata_o <= 32'h0000_0000;
                  bus_write_o <= req_write_i;
                  bus_wdata_o <= req_wdata_i;
                  if (err_r && halt_on_error_i) // R20
                  begin
                     state_r <= ST_RESP; // R21
                     resp_err_o <= !error_forward_disable_i; // R22
                  end
                  else
                  begin
                     state_r <= ST_XFER;
                     bus_req_o <= 1'b1;
                     resp_err_o <= 1'b0;
                     case (req_kind_i)
                        REQ_BANKED:
                        begin
                           // Base address only; the mode never touches it.
                           bus_addr_o <= {tar_r[ADDR_W-1:BANK_LSB], req_index_i[1:0], 2'h0}; // R1 R3
                           size_r <= SIZE_WORD;
                           bus_size_o <= SIZE_WORD;
                           beats_r <= 3'h1;
                        end
                        REQ_DIRECT:
                        begin
                           bus_addr_o <= {tar_r[ADDR_W-1:DIRECT_LSB], req_index_i, 2'h0}; // R1 R3
                           size_r <= SIZE_WORD;
                           bus_size_o <= SIZE_WORD;
                           beats_r <= 3'h1;
                        end
                        default:
                        begin
                           bus_addr_o <= tar_r; // R1
                           size_r <= eff_size(access_size_field_i);
                           bus_size_o <= eff_size(access_size_field_i);
                           if (mode_r == MODE_PACKED && eff_size(access_size_field_i) == SIZE_HALF)
                           begin
                              beats_r <= BEATS_HALF; // R9
                           end
                           else if (mode_r == MODE_PACKED &&
                                    eff_size(access_size_field_i) == SIZE_BYTE)
                           begin
                              beats_r <= BEATS_BYTE; // R10
                           end
                           else
                           begin
                              beats_r <= 3'h1;
                           end
                        end
                     endcase
                  end
               end
            end
            ST_XFER:
            begin
               // No cycle limit: the request stays up until the bus answers or an abort ends it.
               if (done_err) // R14
               begin
                  bus_req_o <= 1'b0;
                  state_r <= ST_RESP;
                  resp_err_o <= abort_i || !error_forward_disable_i; // R22 R23
               end
               else if (beat_ok)
               begin
                  resp_rdata_o <= resp_rdata_o | (bus_rdata_i & lane_mask); // R9
                  if (done_ok)
                  begin
                     bus_req_o <= 1'b0;
                     state_r <= ST_RESP;
                  end
                  else
                  begin
                     beats_r <= beats_r - 3'h1;
                     bus_addr_o <= stp.next; // R10
                  end
               end
            end
            ST_RESP:
            begin
               resp_valid_o <= 1'b1;
               state_r <= ST_IDLE; // R16
            end
            default:
            begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // Status outputs, each from its own flip-flop.
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ready_o <= 1'b0;
         transfer_address_o <= '0;
         addr_step_mode_o <= MODE_OFF;
         incrementer_width_code_o <= 4'h0;
         logged_error_flag_o <= 1'b0;
      end
      else
      begin
         // Ready only while idle with no request arriving from the debug port.
         ready_o <= (state_r == ST_IDLE) && !req_valid_i; // R16
         transfer_address_o <= tar_r;
         addr_step_mode_o <= mode_r;
         incrementer_width_code_o <= WIDTH_CODE; // R12 R13
         logged_error_flag_o <= err_r;
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   a_busy_not_ready: assert property ((state_r != ST_IDLE) |=> !ready_o) // R16
      else $error("ready shown while transfer outstanding");
   a_stall_holds_req: assert property (
      (bus_req_o && !bus_ack_i && !abort_i) |=> bus_req_o && $stable(bus_addr_o)) // R14
      else $error("bus request dropped before answer");
   a_side_keep_tar: assert property (
      (beat_ok && !data_r && !tar_wr_i) |=> $stable(tar_r)) // R3
      else $error("banked or direct access moved address");
   a_err_keep_tar: assert property ((done_err && !tar_wr_i) |=> $stable(tar_r)) // R2
      else $error("address moved on failed access");
   a_single_step: assert property (
      (done_ok && data_r && mode_r == MODE_SINGLE && size_r == SIZE_WORD)
      |=> tar_r[1:0] == $past(tar_r[1:0]) &&
          tar_r[INC_W-1:0] == $past(tar_r[INC_W-1:0]) + INC_W'(4)) // R7
      else $error("single word step not four");
   a_upper_kept: assert property (
      (beat_ok && data_r && !tar_wr_i) |=> tar_r[ADDR_W-1:INC_W] == $past(tar_r[ADDR_W-1:INC_W])) // R24
      else $error("bits above incrementer changed");
   a_packed_code_off: assert property (
      (mode_wr_i && mode_wdata_i == MODE_PACKED && !PACKED_EN) |=> mode_r == MODE_OFF) // R5
      else $error("unsupported packed code not off");
   a_halt_blocks: assert property (
      (state_r == ST_IDLE && req_valid_i && err_r && halt_on_error_i)
      |=> !bus_req_o ##1 resp_valid_o && logged_error_flag_o) // R21
      else $error("access issued while halted on error");
   a_abort_error: assert property ((state_r == ST_XFER && abort_i) |=> ##1 resp_valid_o && resp_err_o) // R23
      else $error("abort did not return error");
   a_err_logged: assert property (done_err |=> err_r ##1 logged_error_flag_o) // R19
      else $error("error not logged");

   c_packed_byte: cover property (done_ok && mode_r == MODE_PACKED && size_r == SIZE_BYTE);
   c_stall: cover property (bus_req_o && !bus_ack_i [*3]);
   c_abort: cover property (state_r == ST_XFER && abort_i);
   c_halted: cover property (state_r == ST_IDLE && req_valid_i && err_r && halt_on_error_i);
endmodule : mem_access_port
`default_nettype wire

// >>> tb/mem_bus_model.sv
// Memory bus target that answers the port after a programmable wait.
`default_nettype none
module mem_bus_model (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Bus from the port.
   input wire logic req_i,
   input wire logic [31:0] addr_i,
   // Bench controls.
   input wire logic [7:0] delay_i,
   input wire logic fail_i,
   // Answer.
   output logic ack_o,
   output logic err_o,
   output logic [31:0] rdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] wait_r;
   logic fire;
   assign fire = req_i && !ack_o && (wait_r >= delay_i);
   // A slow target just lets the request stand, so the port must stall without a limit.
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wait_r <= 8'h00;
         ack_o <= 1'b0;
         err_o <= 1'b0;
         rdata_o <= 32'h00000000;
      end
      else
      begin
         ack_o <= fire;
         err_o <= fire && fail_i;
         wait_r <= (req_i && !ack_o) ? wait_r + 8'h01 : 8'h00;
         // Outside a beat the data lines toggle so a stale value is never mistaken for data.
         rdata_o <= fire ? ~addr_i : ~rdata_o;
      end
   end
endmodule : mem_bus_model
`default_nettype wire

// >>> tb/debug_memory_port_addr_stall_err_test.sv
// Self-checking bench for the debug memory access port.
`default_nettype none
module debug_memory_port_addr_stall_err_test
   import map_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, tar_wr, mode_wr, fwd_dis, halt, clr, rv, rw, abort, fail, e;
   logic ready, rsp_v, rsp_e, flag, breq, bwr, ack, berr, breq2, ack2, berr2;
   logic [31:0] tar_d, rdata, baddr, taddr, taddr2, brd, baddr2, brd2, d, bwd;
   logic [1:0] mode_d, mode_q, mode2;
   logic [2:0] size, bsz, exp_sz;
   logic [3:0] wcode;
   logic [7:0] idx, dly;
   req_kind_t kind;
   logic [31:0] beats[$];
   int n_mismatch = 0;
   int tests_run = 0;

   mem_access_port #(.SUBWORD_EN(1'b1)) uut (.clk_i(clk), .rst_n_i(rst_n), .tar_wr_i(tar_wr),
      .tar_wdata_i(tar_d), .mode_wr_i(mode_wr), .mode_wdata_i(mode_d),
      .access_size_field_i(size), .error_forward_disable_i(fwd_dis), .halt_on_error_i(halt),
      .err_clear_i(clr), .req_valid_i(rv), .req_kind_i(kind), .req_write_i(rw),
      .req_index_i(idx), .req_wdata_i(tar_d), .abort_i(abort), .ready_o(ready),
      .resp_valid_o(rsp_v), .resp_err_o(rsp_e), .resp_rdata_o(rdata),
      .transfer_address_o(taddr), .addr_step_mode_o(mode_q), .incrementer_width_code_o(wcode),
      .logged_error_flag_o(flag), .bus_req_o(breq), .bus_write_o(bwr), .bus_addr_o(baddr),
      .bus_size_o(bsz), .bus_wdata_o(bwd), .bus_ack_i(ack), .bus_err_i(berr), .bus_rdata_i(brd));
   // A word-only build runs in lockstep to show how it treats sub-word and packed settings.
   mem_access_port #(.SUBWORD_EN(1'b0)) uut2 (.clk_i(clk), .rst_n_i(rst_n), .tar_wr_i(tar_wr),
      .tar_wdata_i(tar_d), .mode_wr_i(mode_wr), .mode_wdata_i(mode_d),
      .access_size_field_i(size), .error_forward_disable_i(fwd_dis), .halt_on_error_i(halt),
      .err_clear_i(clr), .req_valid_i(rv), .req_kind_i(kind), .req_write_i(rw),
      .req_index_i(idx), .req_wdata_i(tar_d), .abort_i(abort), .ready_o(), .resp_valid_o(),
      .resp_err_o(), .resp_rdata_o(), .transfer_address_o(taddr2), .addr_step_mode_o(mode2),
      .incrementer_width_code_o(), .logged_error_flag_o(), .bus_req_o(breq2), .bus_write_o(),
      .bus_addr_o(baddr2), .bus_size_o(), .bus_wdata_o(), .bus_ack_i(ack2), .bus_err_i(berr2),
      .bus_rdata_i(brd2));
   mem_bus_model bus (.clk_i(clk), .rst_n_i(rst_n), .req_i(breq), .addr_i(baddr),
      .delay_i(dly), .fail_i(fail), .ack_o(ack), .err_o(berr), .rdata_o(brd));
   mem_bus_model bus2 (.clk_i(clk), .rst_n_i(rst_n), .req_i(breq2), .addr_i(baddr2),
      .delay_i(dly), .fail_i(fail), .ack_o(ack2), .err_o(berr2), .rdata_o(brd2));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // Byte lanes that a beat of the given size fills at the given low address bits.
   function automatic logic [31:0] lane_of(input logic [2:0] s, input logic [1:0] a);
      if (s == SIZE_BYTE)
         lane_of = 32'h000000FF << {a, 3'b000};
      else if (s == SIZE_HALF)
         lane_of = a[1] ? 32'hFFFF0000 : 32'h0000FFFF;
      else
         lane_of = 32'hFFFFFFFF;
   endfunction : lane_of

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict

   task automatic access(input req_kind_t k, input logic [7:0] i);
      int n;
      n = 0;
      @(negedge clk);
      while (ready !== 1'b1 && n < 300)
      begin
         @(negedge clk);
         n++;
      end
      kind = k;
      idx = i;
      rv = 1'b1;
      @(negedge clk);
      rv = 1'b0;
      n = 0;
      while (rsp_v !== 1'b1 && n < 300)
      begin
         @(negedge clk);
         n++;
      end
      if (n == 300)
         n_mismatch++;
      e = rsp_e;
      d = rdata;
      @(negedge clk);
   endtask : access

   task automatic xfer(input logic [1:0] m, input logic [2:0] s, input req_kind_t k,
      input logic [7:0] i, input logic [31:0] t, input int nb, input int st,
      input logic [31:0] tend);
      logic [31:0] base;
      logic [31:0] acc;
      base = (k == REQ_DATA) ? t : (k == REQ_BANKED) ? {t[31:4], i[1:0], 2'b00}
         : {t[31:10], i, 2'b00};
      exp_sz = (k == REQ_DATA) ? s : SIZE_WORD;
      tar_d = t;
      tar_wr = 1'b1;
      mode_d = m;
      mode_wr = 1'b1;
      size = s;
      @(negedge clk);
      tar_wr = 1'b0;
      mode_wr = 1'b0;
      beats.delete();
      access(k, i);
      check(32'(beats.size()), 32'(nb));
      foreach (beats[j]) check(beats[j], base + 32'(j * st));
      check(32'(e), 32'h00000000);
      check(taddr, tend);
      check(32'(mode_q), 32'(m));
      check(32'(mode2), (m == MODE_PACKED) ? 32'h00000000 : 32'(m));
      check(taddr2, (k == REQ_DATA && m == MODE_SINGLE) ? {t[31:10], t[9:0] + 10'h004} : t);
      acc = 32'h00000000;
      for (int j = 0; j < nb; j++)
         acc = acc | (~(base + 32'(j * st)) & lane_of(exp_sz, 2'(base + 32'(j * st))));
      if (!rw)
         check(d, acc);
   endtask : xfer

   task automatic err_case(input logic fd, input logic hl, input logic fl, input logic ee,
      input int nb);
      fwd_dis = fd;
      halt = hl;
      fail = fl;
      beats.delete();
      access(REQ_DATA, 8'h00);
      check(32'(e), 32'(ee));
      check(32'(beats.size()), 32'(nb));
      check(32'(flag), 32'h00000001);
      check(taddr, 32'h00000200);
   endtask : err_case

   always @(negedge clk)
      if (breq && ack)
      begin
         beats.push_back(baddr);
         check(32'(bwr), 32'(rw));
         check(32'(bsz), 32'(exp_sz));
         check(bwd, tar_d);
      end

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   initial
   begin
      #50000;
      n_mismatch++;
      print_verdict();
   end

   initial
   begin
      {rst_n, tar_wr, mode_wr, fwd_dis, halt, clr, rv, rw, abort, fail} = '0;
      tar_d = 32'h00000000;
      mode_d = MODE_OFF;
      size = SIZE_WORD;
      exp_sz = SIZE_WORD;
      idx = 8'h00;
      dly = 8'h00;
      kind = REQ_DATA;
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      check(32'(wcode), 32'h00000001);
      check(32'(ready), 32'h00000001);
      xfer(MODE_SINGLE, SIZE_WORD, REQ_DATA, 8'h00, 32'h000013F8, 1, 4, 32'h000013FC);
      xfer(MODE_SINGLE, SIZE_WORD, REQ_DATA, 8'h00, 32'hABCD17FC, 1, 4, 32'hABCD1400);
      xfer(MODE_PACKED, SIZE_BYTE, REQ_DATA, 8'h00, 32'h00000200, 4, 1, 32'h00000204);
      rw = 1'b1;
      xfer(MODE_OFF, SIZE_WORD, REQ_DATA, 8'h00, 32'h00000040, 1, 0, 32'h00000040);
      xfer(MODE_SINGLE, SIZE_HALF, REQ_DATA, 8'h00, 32'h00000040, 1, 0, 32'h00000042);
      xfer(MODE_SINGLE, SIZE_BYTE, REQ_DATA, 8'h00, 32'h00000040, 1, 0, 32'h00000041);
      xfer(MODE_PACKED, SIZE_HALF, REQ_DATA, 8'h00, 32'h00000100, 2, 2, 32'h00000104);
      xfer(MODE_PACKED, SIZE_BYTE, REQ_DATA, 8'h00, 32'h00000101, 4, 1, 32'h00000105);
      xfer(2'h3, SIZE_WORD, REQ_DATA, 8'h00, 32'h00000080, 1, 0, 32'h00000080);
      xfer(MODE_SINGLE, SIZE_WORD, REQ_BANKED, 8'h02, 32'h12345670, 1, 0, 32'h12345670);
      xfer(MODE_SINGLE, SIZE_WORD, REQ_DIRECT, 8'hA5, 32'h12345670, 1, 0, 32'h12345670);
      $display("test addressing done");
      xfer(MODE_SINGLE, SIZE_WORD, REQ_DATA, 8'h00, 32'h000001FC, 1, 0, 32'h00000200);
      err_case(1'b0, 1'b0, 1'b1, 1'b1, 1);
      err_case(1'b1, 1'b0, 1'b1, 1'b0, 1);
      err_case(1'b0, 1'b1, 1'b0, 1'b1, 0);
      clr = 1'b1;
      @(negedge clk);
      clr = 1'b0;
      @(negedge clk);
      check(32'(flag), 32'h00000000);
      $display("test errors done");
      dly = 8'h14;
      beats.delete();
      fork
         access(REQ_DATA, 8'h00);
         begin
            repeat (6) @(negedge clk);
            check(32'(ready), 32'h00000000);
            rv = 1'b1;
            @(negedge clk);
            rv = 1'b0;
         end
      join
      check(32'(beats.size()), 32'h00000001);
      check(taddr, 32'h00000204);
      dly = 8'h32;
      fwd_dis = 1'b1;
      fork
         access(REQ_DATA, 8'h00);
         begin
            repeat (8) @(negedge clk);
            abort = 1'b1;
            @(negedge clk);
            abort = 1'b0;
         end
      join
      check(32'(e), 32'h00000001);
      check(32'(flag), 32'h00000001);
      check(taddr, 32'h00000204);
      $display("test stall and abort done");
      print_verdict();
   end
endmodule : debug_memory_port_addr_stall_err_test
`default_nettype wire
